// >>> hdl/synth_cfg_pkg.sv
// Package with constants shared by the serial slave port and its master end
`default_nettype none
package synth_cfg_pkg;
  localparam logic [6:0] SLAVE_ADDR       = 7'h69;     // Address byte 0xd2 write, 0xd3 read
  localparam logic [7:0] REG_XTAL_DIV     = 8'h00;     // crystal_divider_config
  localparam logic [7:0] REG_SYNTH_CTRL   = 8'h08;     // synth_control
  localparam logic [7:0] REG_CARRIER_HIGH = 8'h0b;     // carrier_word_high
  localparam logic [7:0] REG_CARRIER_MID  = 8'h0c;     // carrier_word_mid
  localparam logic [7:0] REG_CARRIER_LOW  = 8'h0d;     // carrier_word_low
  localparam logic [7:0] REG_AMP_LEVEL    = 8'h04;     // Amplifier level register, own offset
  localparam logic [7:0] RST_XTAL_DIV     = 8'h10;     // Divider code 01 (divide by 5)
  localparam logic [7:0] RST_SYNTH_CTRL   = 8'h01;     // Fractional mode on, band 0
  localparam logic [7:0] RST_CARRIER      = 8'h00;     // Carrier bytes after reset
  localparam logic [7:0] RST_AMP_LEVEL    = 8'h07;     // Full power after reset
  localparam int         XDIV_POS         = 4;         // crystal_divider_field low bit
  localparam int         FRAC_POS         = 0;         // fractional_enable bit
  localparam int         LO_BAND_DIVIDER_POS        = 2;         // lo_band_divider low bit
  localparam logic [2:0] AMP_MAX          = 3'h7;      // Maximum amplifier code
  localparam logic [1:0] XDIV_BY4         = 2'h0;      // Divider codes
  localparam logic [1:0] XDIV_BY5         = 2'h1;
  localparam logic [1:0] XDIV_BY6         = 2'h2;
  localparam int         CLK_HZ           = 25000000;  // System clock rate
  localparam int         BUS_HZ           = 100000;    // Bus rate HALF_BIT_CYC is sized from; the master clocks at 50 kHz
  localparam int         HALF_BIT_CYC     = CLK_HZ / (2 * BUS_HZ); // Cycles per half bit at BUS_HZ, used by the master per quarter bit
  localparam logic [7:0] M_CTRL           = 8'h00;     // Master command register
  localparam logic [7:0] M_ADDR           = 8'h04;     // Master register address
  localparam logic [7:0] M_WDATA          = 8'h08;     // Master write byte
  localparam logic [7:0] M_STATUS         = 8'h0c;     // Master status/read byte
endpackage : synth_cfg_pkg
`default_nettype wire

// >>> hdl/two_wire_if.sv
// Interface joining the two ends of the open-drain bus
`default_nettype none
interface two_wire_if;
  logic scl_oe;   // Master pulls clock low
  logic sda_m_oe; // Master pulls data low
  logic sda_s_oe; // Slave pulls data low
  logic scl;      // Resolved clock line
  logic sda;      // Resolved data line
  assign scl = ~scl_oe;                      // Pull-up wins when nobody drives
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport device (input scl, input sda, output sda_s_oe);
  modport host   (input scl, input sda, output scl_oe, output sda_m_oe);
endinterface : two_wire_if
`default_nettype wire

// >>> hdl/synth_cfg_slave.sv
// Serial slave port holding the synthesizer configuration registers
`default_nettype none
module synth_cfg_slave
  import synth_cfg_pkg::*;
(
  input  wire logic       clk_i,          // 25 MHz clock
  input  wire logic       rst_i,          // Synchronous reset, high
  two_wire_if.device      bus,            // Two-wire bus
  input  wire logic       sel_low_gnd_i,  // preset_select_low_pin grounded
  input  wire logic       sel_high_gnd_i, // preset_select_high_pin grounded
  output logic [2:0]      amp_level_o,    // amplifier_level_field in effect
  output logic [1:0]      xtal_div_o,     // crystal_divider_field
  output logic [2:0]      xtal_ratio_o,   // Divide ratio 4, 5 or 6
  output logic [23:0]     carrier_word_o, // carrier_word
  output logic [1:0]      lo_band_o,      // lo_band_divider
  output logic            frac_en_o,      // fractional_enable
  output logic            osc_start_o     // One-cycle oscillator wake pulse
);
  import synth_cfg_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,  // Waiting for START
    S_RX   = 5'b00010,  // Shifting in a byte
    S_ACK  = 5'b00100,  // Driving acknowledge
    S_TX   = 5'b01000,  // Shifting out a byte
    S_MACK = 5'b10000   // Sampling master acknowledge
  } state_e;

  state_e      state;         // Byte-level state
  logic [1:0]  scl_sync;      // Clock synchroniser
  logic [1:0]  sda_sync;      // Data synchroniser
  logic        scl_d;         // Previous synchronised clock
  logic        sda_d;         // Previous synchronised data
  logic [3:0]  bit_cnt;       // Bits of current byte
  logic [7:0]  shift;         // Receive/transmit shift register
  logic [1:0]  byte_idx;      // 0 address byte, 1 register byte, 2 data
  logic        read_dir;      // Read phase after address
  logic        addressed;     // Current byte acknowledged
  logic [7:0]  reg_ptr;       // Register pointer
  logic [7:0]  r_xdiv;        // crystal_divider_config
  logic [7:0]  r_synth;       // synth_control
  logic [7:0]  r_hi;          // carrier_word_high
  logic [7:0]  r_mid;         // carrier_word_mid
  logic [7:0]  r_lo;          // carrier_word_low
  logic [7:0]  r_amp;         // Programmed amplifier level
  logic        sda_drv;       // Drive data low
  logic [1:0]  sel_lo_sync;   // preset_select_low_pin synchroniser
  logic [1:0]  sel_hi_sync;   // preset_select_high_pin synchroniser

  // Bus lines pass two flops before any edge logic
  always_ff @(posedge clk_i) begin
    scl_sync <= {scl_sync[0], bus.scl};
    sda_sync <= {sda_sync[0], bus.sda};
    // Select pins are strapped outside the clock domain, so they pass two flops too
    sel_lo_sync <= {sel_lo_sync[0], sel_low_gnd_i};
    sel_hi_sync <= {sel_hi_sync[0], sel_high_gnd_i};
    scl_d    <= scl_sync[1];
    sda_d    <= sda_sync[1];
  end

  wire scl_s    = scl_sync[1];
  wire sda_s    = sda_sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire port_en  = sel_lo_sync[1] & sel_hi_sync[1];
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire addr_hit = (shift[7:1] == SLAVE_ADDR);

  // Read mux; unmapped registers read zero
  wire [7:0] rd_data =
    (reg_ptr == REG_XTAL_DIV)     ? r_xdiv  :
    (reg_ptr == REG_SYNTH_CTRL)   ? r_synth :
    (reg_ptr == REG_CARRIER_HIGH) ? r_hi    :
    (reg_ptr == REG_CARRIER_MID)  ? r_mid   :
    (reg_ptr == REG_CARRIER_LOW)  ? r_lo    :
    (reg_ptr == REG_AMP_LEVEL)    ? r_amp   : 8'h00;

  // Byte engine; START/STOP always restart the search for our address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= S_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      byte_idx  <= 2'h0;
      read_dir  <= 1'b0;
      addressed <= 1'b0;
      reg_ptr   <= 8'h00;
      sda_drv   <= 1'b0;
      osc_start_o <= 1'b0;
      r_xdiv    <= RST_XTAL_DIV;
      r_synth   <= RST_SYNTH_CTRL;
      r_hi      <= RST_CARRIER;
      r_mid     <= RST_CARRIER;
      r_lo      <= RST_CARRIER;
      r_amp     <= RST_AMP_LEVEL;
    end else begin
      osc_start_o <= 1'b0;
      if (!port_en || stop_c) begin
        state   <= S_IDLE;
        sda_drv <= 1'b0;
      end else if (start_c) begin
        state    <= S_RX;
        bit_cnt  <= 4'h0;
        byte_idx <= 2'h0;
        read_dir <= 1'b0;
        sda_drv  <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            sda_drv <= 1'b0;
          end
          S_RX: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              state   <= S_ACK;
              if (byte_idx == 2'h0) begin
                addressed <= addr_hit;
                sda_drv   <= addr_hit;
                read_dir  <= shift[0];
                osc_start_o <= addr_hit;
              end else begin
                addressed <= 1'b1;
                sda_drv   <= 1'b1;
                if (byte_idx == 2'h1) begin
                  reg_ptr <= shift;
                end else begin
                  reg_ptr <= reg_ptr + 8'h01;
                  if (reg_ptr == REG_XTAL_DIV)     r_xdiv  <= shift;
                  if (reg_ptr == REG_SYNTH_CTRL)   r_synth <= shift;
                  if (reg_ptr == REG_CARRIER_HIGH) r_hi    <= shift;
                  if (reg_ptr == REG_CARRIER_MID)  r_mid   <= shift;
                  if (reg_ptr == REG_CARRIER_LOW)  r_lo    <= shift;
                  if (reg_ptr == REG_AMP_LEVEL)    r_amp   <= shift;
                end
              end
            end
          end
          S_ACK: begin
            // Release after ninth clock; not-ack leaves data high
            if (scl_fall) begin
              if (!addressed) begin
                sda_drv <= 1'b0;
                state   <= S_IDLE;
              end else if (byte_idx == 2'h0 && read_dir) begin
                shift   <= rd_data;
                reg_ptr <= reg_ptr + 8'h01;
                sda_drv <= ~rd_data[7];
                state   <= S_TX;
              end else begin
                sda_drv  <= 1'b0;
                byte_idx <= (byte_idx == 2'h2) ? 2'h2 : byte_idx + 2'h1;
                state    <= S_RX;
              end
            end
          end
          S_TX: begin
            // MSB first; next bit placed on falling clock
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                bit_cnt <= 4'h0;
                sda_drv <= 1'b0;
                state   <= S_MACK;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
                shift   <= {shift[6:0], 1'b0};
                sda_drv <= ~shift[6];
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state <= S_IDLE;
              end else begin
                shift <= rd_data;
                reg_ptr <= reg_ptr + 8'h01;
              end
            end else if (scl_fall) begin
              state   <= S_TX;
              sda_drv <= ~shift[7];
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  assign bus.sda_s_oe   = sda_drv;
  assign amp_level_o    = port_en ? r_amp[2:0] : AMP_MAX;
  assign xtal_div_o     = r_xdiv[XDIV_POS+1:XDIV_POS];
  assign xtal_ratio_o   = (xtal_div_o == XDIV_BY4) ? 3'h4 :
                          (xtal_div_o == XDIV_BY5) ? 3'h5 :
                          (xtal_div_o == XDIV_BY6) ? 3'h6 : 3'h5;
  assign carrier_word_o = {r_hi, r_mid, r_lo};
  assign lo_band_o      = r_synth[LO_BAND_DIVIDER_POS+1:LO_BAND_DIVIDER_POS];
  assign frac_en_o      = r_synth[FRAC_POS];
endmodule : synth_cfg_slave
`default_nettype wire

// >>> hdl/synth_cfg_master.sv
// Bus master end driven by Wishbone command registers
`default_nettype none
module synth_cfg_master
  import synth_cfg_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT_CYC  // Cycles per quarter bus clock period
) (
  input  wire logic       clk_i,   // 25 MHz clock
  input  wire logic       rst_i,   // Synchronous reset, high
  two_wire_if.host        bus,     // Two-wire bus
  input  wire logic       cyc_i,   // Wishbone cycle
  input  wire logic       stb_i,   // Wishbone strobe
  input  wire logic       we_i,    // Wishbone write
  input  wire logic [7:0] adr_i,   // Wishbone byte address
  input  wire logic [3:0] sel_i,   // Wishbone byte selects
  input  wire logic [31:0] dat_i,  // Wishbone write data
  output logic [31:0]     dat_o,   // Wishbone read data
  output logic            ack_o    // Wishbone acknowledge
);
  import synth_cfg_pkg::*;

  typedef enum logic [5:0] {
    M_IDLE  = 6'b000001, // Bus idle
    M_START = 6'b000010, // Generating START
    M_BIT   = 6'b000100, // Clocking 9 bits
    M_STOP  = 6'b001000, // Generating STOP
    M_DONE  = 6'b010000, // Sequence done
    M_RSTRT = 6'b100000  // Repeated START
  } mstate_e;

  mstate_e     st;          // Sequencer state
  logic [15:0] tmr;         // Quarter-bit timer
  logic [1:0]  ph;          // Quarter phase within bit
  logic [3:0]  bitn;        // Bit index 0..8
  logic [8:0]  txs;         // Byte plus ack bit to send
  logic [7:0]  rxs;         // Received byte
  logic [1:0]  step;        // Byte index in sequence
  logic        op_read;     // Command is a read
  logic        busy;        // Command active
  logic        nack;        // Slave refused a byte
  logic [7:0]  r_addr;      // Target register
  logic [7:0]  r_wdata;     // Write byte
  logic [7:0]  r_rdata;     // Last read byte
  logic        scl_lo;      // Drive clock low
  logic        sda_lo;      // Drive data low
  logic [1:0]  sda_sync;    // Data synchroniser

  always_ff @(posedge clk_i) begin
    sda_sync <= {sda_sync[0], bus.sda};
  end

  wire tick = (tmr == 16'(HALF_CYC - 1));
  wire go   = cyc_i & stb_i & ~ack_o & we_i & (adr_i == M_CTRL) & sel_i[0] & dat_i[0];

  // Which byte goes out at each step: address, register, data or read address
  wire [7:0] next_byte =
    (step == 2'h0) ? {SLAVE_ADDR, 1'b0} :
    (step == 2'h1) ? r_addr :
    (op_read)      ? {SLAVE_ADDR, 1'b1} : r_wdata;

  // Wishbone slave: one wait-free answer the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      dat_o   <= 32'h0;
      r_addr  <= 8'h00;
      r_wdata <= 8'h00;
      op_read <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (cyc_i && stb_i && !ack_o && we_i && !busy) begin
        if (adr_i == M_ADDR)  r_addr  <= dat_i[7:0];
        if (adr_i == M_WDATA) r_wdata <= dat_i[7:0];
        if (adr_i == M_CTRL)  op_read <= dat_i[1];
      end
      if (adr_i == M_STATUS)     dat_o <= {22'h0, busy, nack, r_rdata};
      else if (adr_i == M_ADDR)  dat_o <= {24'h0, r_addr};
      else if (adr_i == M_WDATA) dat_o <= {24'h0, r_wdata};
      else                       dat_o <= 32'h0;
    end
  end

  // Bit sequencer: master makes every clock and every START
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= M_IDLE; tmr <= 16'h0; ph <= 2'h0; bitn <= 4'h0;
      txs <= 9'h1ff; rxs <= 8'h00; step <= 2'h0; busy <= 1'b0;
      nack <= 1'b0; r_rdata <= 8'h00; scl_lo <= 1'b0; sda_lo <= 1'b0;
    end else begin
      tmr <= tick ? 16'h0 : tmr + 16'h1;
      case (st)
        M_IDLE: begin
          scl_lo <= 1'b0; sda_lo <= 1'b0;
          if (go && !busy) begin
            busy <= 1'b1; nack <= 1'b0; step <= 2'h0;
            st <= M_START; tmr <= 16'h0;
          end
        end
        M_START: if (tick) begin
          sda_lo <= 1'b1;
          txs    <= {next_byte, 1'b1};
          bitn   <= 4'h0;
          ph     <= 2'h0;
          st     <= M_BIT;
        end
        // Repeated START: clock low, data released, clock high, then data falls;
        // without the high clock phase the slave would take the byte as data
        M_RSTRT: if (tick) begin
          ph <= ph + 2'h1;
          if (ph == 2'h0) begin
            scl_lo <= 1'b1;
            sda_lo <= 1'b0;
          end else if (ph == 2'h2) begin
            scl_lo <= 1'b0;
          end else if (ph == 2'h3) begin
            sda_lo <= 1'b1;
            txs    <= {next_byte, 1'b1};
            bitn   <= 4'h0;
            st     <= M_BIT;
          end
        end
        M_BIT: if (tick) begin
          ph <= ph + 2'h1;
          if (ph == 2'h0) begin
            scl_lo <= 1'b1;
          end else if (ph == 2'h1) begin
            sda_lo <= ~txs[8];
          end else if (ph == 2'h2) begin
            scl_lo <= 1'b0;
          end else begin
            rxs  <= {rxs[6:0], sda_sync[1]};
            txs  <= {txs[7:0], 1'b1};
            bitn <= bitn + 4'h1;
            if (bitn == 4'h8) begin
              if (op_read && step == 2'h3) begin
                r_rdata <= rxs; st <= M_STOP;
              end else if (sda_sync[1]) begin
                nack <= 1'b1; st <= M_STOP;
              end else if (op_read && step == 2'h1) begin
                step <= 2'h2;
                st   <= M_RSTRT;
              end else if (op_read && step == 2'h2) begin
                step <= 2'h3;
                bitn <= 4'h0;
                txs  <= 9'h1ff;                     // Master not-acks last byte
              end else if (step == 2'h2) begin
                st <= M_STOP;
              end else begin
                step <= step + 2'h1; bitn <= 4'h0;
                txs <= {(step == 2'h0) ? r_addr : r_wdata, 1'b1};
              end
            end
          end
        end
        M_STOP: if (tick) begin
          ph <= ph + 2'h1;
          if (ph == 2'h0) scl_lo <= 1'b1;
          else if (ph == 2'h1) sda_lo <= 1'b1;
          else if (ph == 2'h2) scl_lo <= 1'b0;
          else begin sda_lo <= 1'b0; st <= M_DONE; end
        end
        default: begin busy <= 1'b0; st <= M_IDLE; end
      endcase
    end
  end

  assign bus.scl_oe   = scl_lo;
  assign bus.sda_m_oe = sda_lo;
endmodule : synth_cfg_master
`default_nettype wire

// >>> dv/synth_cfg_bus_asserts.sv
// Checker watching the two-wire bus between the master and slave ends
`default_nettype none
module synth_cfg_bus_asserts
  import synth_cfg_pkg::*;
(
  input  wire logic clk_i,          // System clock
  input  wire logic rst_i,          // Synchronous reset, high
  input  wire logic scl_oe,         // Master pulls clock low
  input  wire logic sda_m_oe,       // Master pulls data low
  input  wire logic sda_s_oe,       // Slave pulls data low
  input  wire logic scl,            // Resolved clock line
  input  wire logic sda,            // Resolved data line
  input  wire logic sel_low_gnd_i,  // Low select pin grounded
  input  wire logic sel_high_gnd_i  // High select pin grounded
);
  logic       scl_q;  // Clock one cycle ago
  logic       sda_q;  // Data one cycle ago
  logic [3:0] bits;   // Clock rises in the current nine-clock frame
  logic [3:0] bits_prev; // Count before the latest rise
  logic       first;  // Still inside the address byte
  logic [7:0] sh;     // Data sampled on clock rises
  wire        rise_w  = scl & ~scl_q;
  wire        start_w = scl & scl_q & sda_q & ~sda;
  wire        port_w  = sel_low_gnd_i & sel_high_gnd_i;
  // Bit position tracking, so that the address acknowledge slot can be found
  always_ff @(posedge clk_i) begin
    scl_q <= rst_i | scl;
    sda_q <= rst_i | sda;
    if (rst_i || start_w) begin
      bits      <= 4'h0;
      bits_prev <= 4'h0;
      first     <= 1'b1;
    end else if (rise_w) begin
      bits      <= (bits == 4'h9) ? 4'h1 : bits + 4'h1;
      bits_prev <= bits;
      first     <= first & (bits != 4'h9);
      sh        <= {sh[6:0], sda};
    end
  end
  // The clock pulse of a STOP or repeated START is the rise after the ninth,
  // so a whole frame shows bits 1 with bits_prev 9 at that condition
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  // Acknowledge only our own address, and only with the port enabled
  AST_ADDR_ACK: assert property (rise_w && bits == 4'h8 && first |->
    sda_s_oe == (port_w && sh[7:1] == SLAVE_ADDR)) else $error("address acknowledge wrong");
  AST_SLAVE_STABLE: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave moved data while clock high");
  AST_START_FREE: assert property (start_s |-> !sda_s_oe && sda_m_oe)
    else $error("slave drove data at START");
  AST_STOP_IDLE: assert property (stop_s |-> !sda_s_oe && !scl_oe ##1 scl && sda)
    else $error("lines not released at STOP");
  AST_PRESET_QUIET: assert property (!port_w |-> !sda_s_oe)
    else $error("slave drove data in preset mode");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  AST_STOP_FRAME: assert property (stop_s |-> bits == 4'h1 && bits_prev == 4'h9)
    else $error("STOP not after a whole byte");
  AST_START_FRAME: assert property (start_s |->
    bits == 4'h0 || (bits == 4'h1 && bits_prev == 4'h9)) else $error("START inside a byte");
  AST_ACK_HELD: assert property (rise_w && sda_s_oe |-> !sda ##1 sda_s_oe [*6])
    else $error("acknowledge not held");
endmodule : synth_cfg_bus_asserts
`default_nettype wire

// >>> dv/tb_synth_config_i2c_slave.sv
// Testbench joining the master and slave ends over the two-wire bus
`default_nettype none
module tb_synth_config_i2c_slave;
  timeunit 1ns;
  timeprecision 1ns;
  import synth_cfg_pkg::*;
  logic        clk_i = 1'b0;    // 25 MHz clock
  logic        rst_i = 1'b1;    // Reset, high
  logic        cyc_i = 1'b0;    // Wishbone request
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;           // Wishbone answer
  logic        ack_o;
  logic [1:0]  sel_gnd = 2'h3;  // {high, low} select pins grounded
  logic [2:0]  amp_level;       // Slave outputs
  logic [2:0]  xtal_ratio;
  logic [1:0]  xtal_div;
  logic [1:0]  lo_band;
  logic [23:0] carrier_word;
  logic        frac_en;
  logic        osc_start;
  logic [31:0] rd;              // Last Wishbone read data
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          osc_seen = 0;    // Wake pulses counted
  int          base;
  two_wire_if bus_if ();
  // Quarter period 13 keeps the bus under 1 MHz, the slave's stated ceiling
  synth_cfg_master #(.HALF_CYC(13)) synth_cfg_master_inst (.clk_i(clk_i), .rst_i(rst_i),
    .bus(bus_if), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
  synth_cfg_slave synth_cfg_slave_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if),
    .sel_low_gnd_i(sel_gnd[0]), .sel_high_gnd_i(sel_gnd[1]), .amp_level_o(amp_level),
    .xtal_div_o(xtal_div), .xtal_ratio_o(xtal_ratio), .carrier_word_o(carrier_word),
    .lo_band_o(lo_band), .frac_en_o(frac_en), .osc_start_o(osc_start));
  synth_cfg_bus_asserts synth_cfg_bus_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
    .scl_oe(bus_if.scl_oe), .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe),
    .scl(bus_if.scl), .sda(bus_if.sda), .sel_low_gnd_i(sel_gnd[0]),
    .sel_high_gnd_i(sel_gnd[1]));
  // Free-running clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Count oscillator wake pulses; each stands one cycle
  always @(posedge clk_i) begin
    if (osc_start === 1'b1) begin
      osc_seen++;
    end
  end
  // Closing report, also reached when a wait runs out
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One classic cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
    @(posedge clk_i);
  endtask : wb
  // One bus transfer through the master, waiting until it is no longer busy
  task automatic xfer(input logic rdn, input logic [7:0] ra, input logic [7:0] wd);
    int n;
    n = 0;
    wb(1'b1, M_ADDR, {24'h0, ra});
    wb(1'b1, M_WDATA, {24'h0, wd});
    wb(1'b1, M_CTRL, {30'h0, rdn, 1'b1});
    do begin
      wb(1'b0, M_STATUS, 32'h0);
      n++;
    end while (rd[9] !== 1'b0 && n < 1000);
    if (rd[9] !== 1'b0) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : xfer
  task automatic put(input logic [7:0] ra, input logic [7:0] v);
    xfer(1'b0, ra, v);
    check("write acknowledge", 32'(rd[8]), 32'h0);
  endtask : put
  task automatic rchk(input string what, input logic [7:0] ra, input logic [7:0] exp);
    xfer(1'b1, ra, 8'h00);
    check(what, {23'h0, rd[8:0]}, {24'h0, exp});
  endtask : rchk
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("divider reset", REG_XTAL_DIV, RST_XTAL_DIV);
    rchk("synth reset", REG_SYNTH_CTRL, RST_SYNTH_CTRL);
    rchk("amp reset", REG_AMP_LEVEL, RST_AMP_LEVEL);
    check("ratio reset", 32'(xtal_ratio), 32'h5);
    $display("test reset done");
    // Divider codes 0 to 2
    for (int c = 0; c < 3; c++) begin
      put(REG_XTAL_DIV, 8'(c << XDIV_POS));
      check("divider code", 32'(xtal_div), 32'(c));
      check("divider ratio", 32'(xtal_ratio), 32'(c + 4));
    end
    $display("test divider done");
    // Carrier bytes with an odd low bit; one address acknowledge gives one wake pulse
    base = osc_seen;
    put(REG_CARRIER_HIGH, 8'h12);
    check("wake on write", 32'(osc_seen - base), 32'h1);
    put(REG_CARRIER_MID, 8'h34);
    put(REG_CARRIER_LOW, 8'h57);
    check("carrier", 32'(carrier_word), 32'h123457);
    base = osc_seen;
    rchk("carrier mid", REG_CARRIER_MID, 8'h34);
    check("wake on read", 32'(osc_seen - base), 32'h2);
    $display("test carrier done");
    // Every band with fractional mode off and on; other control bits written zero
    for (int b = 0; b < 8; b++) begin
      put(REG_SYNTH_CTRL, 8'(((b >> 1) << LO_BAND_DIVIDER_POS) | ((b & 1) << FRAC_POS)));
      check("band", 32'(lo_band), 32'(b >> 1));
      check("fractional", 32'(frac_en), 32'(b & 1));
    end
    $display("test synth done");
    // Unmapped places: slave reads zero, master still acknowledges and reads zero
    put(8'h05, 8'haa);
    rchk("unmapped", 8'h05, 8'h00);
    wb(1'b0, 8'h10, 32'h0);
    check("master unmapped", rd, 32'h0);
    // Preset combinations force full power and refuse the bus
    put(REG_AMP_LEVEL, 8'h03);
    check("amp programmed", 32'(amp_level), 32'h3);
    for (int p = 0; p < 3; p++) begin
      sel_gnd <= 2'(p);
      // Select pins pass two flops in the slave; look on the third edge
      repeat (3) @(posedge clk_i);
      check("amp preset", 32'(amp_level), 32'h7);
      xfer(1'b0, REG_CARRIER_LOW, 8'h99);
      check("preset refused", 32'(rd[8]), 32'h1);
      check("carrier kept", 32'(carrier_word), 32'h123457);
    end
    sel_gnd <= 2'h3;
    repeat (3) @(posedge clk_i);
    check("amp restored", 32'(amp_level), 32'h3);
    rchk("carrier low", REG_CARRIER_LOW, 8'h57);
    $display("test preset done");
    give_verdict();
  end
endmodule : tb_synth_config_i2c_slave
`default_nettype wire
